// >>> design/bus_edge_detect.sv
// edge detector for the single-wire bus receive level.
// assumes the level is already synchronous to clk_i; the bus idles high.
`timescale 1ns/1ps
module bus_edge_detect (
  input wire logic clk_i,    // system clock
  input wire logic rst_i,    // synchronous reset, high
  input wire logic level_i,  // bus level
  output logic rise_o,       // one-cycle rising edge
  output logic fall_o        // one-cycle falling edge
);

  logic prev_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_ff <= 1'b1;
    else
      prev_ff <= level_i;
  end

  assign rise_o = level_i & ~prev_ff;
  assign fall_o = ~level_i & prev_ff;

endmodule

// >>> design/pulse_timer.sv
// break pulse timer: restarts from zero on start, halts on stop,
// gives registered one-cycle pulses on compare match and on overflow.
// assumes start and stop are one-cycle pulses; start wins over stop.
`timescale 1ns/1ps
module pulse_timer #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_i,              // system clock
  input wire logic rst_i,              // synchronous reset, high
  input wire logic start_i,            // clear and run
  input wire logic stop_i,             // halt, count kept
  input wire logic [WIDTH-1:0] cmp_i,  // compare value
  output logic [WIDTH-1:0] count_o,    // running count
  output logic run_o,                  // timer running
  output logic match_o,                // count reached compare value
  output logic ovf_o                   // count wrapped
);

  logic [WIDTH-1:0] count_ff;
  logic run_ff;
  logic match_ff;
  logic ovf_ff;
  logic [WIDTH-1:0] nxt_count;
  logic stepping;

  assign nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
  assign stepping = run_ff & ~start_i & ~stop_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_ff <= '0;
      run_ff <= 1'b0;
    end
    else if (start_i)
    begin
      count_ff <= '0;
      run_ff <= 1'b1;
    end
    else if (stop_i)
      run_ff <= 1'b0;
    else if (run_ff)
    begin
      count_ff <= nxt_count;
      // halt on wrap so a stuck bus shows as a fault
      if (&count_ff)
        run_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      match_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end
    else
    begin
      match_ff <= stepping & (nxt_count == cmp_i);
      ovf_ff <= stepping & (&count_ff);
    end
  end

  assign count_o = count_ff;
  assign run_o = run_ff;
  assign match_o = match_ff;
  assign ovf_o = ovf_ff;

endmodule

// >>> design/sync_link_ctrl.sv
// break and sync gating block with Wishbone register slave.
// assumes bus pins are synchronous to clk_i and the bus idles high.
//
// Operation
// - control bit 10 masks break timer error interrupt
// - bit 9 routes test pins to transceiver
// - bit 9 clear connects transceiver to UART; the code drives transmit from config bit 1 in bit-serial mode
// - UART mode, bit 8 holds receive high
// - bit 8 clear passes receive data after sync; the code passes it at once, with no break or sync needed
// - bit-serial read, bit 8 flags rising edge
// - timer runs falling edge to rising edge
// - interrupt when timer count equals compare value
// - interrupt when break timer overflows
// - bit 8 clear blocks rising edge interrupt
// - compare status bit 3 times pulse release
// - write mode timer still stops on rising
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module sync_link_ctrl #(
  parameter int unsigned TIMER_WIDTH = 16,
  parameter int unsigned BREAK_CYCLES = sync_link_pkg::BREAK_CYCLES
) (
  input wire logic clk_i,          // system clock, 100 MHz
  input wire logic rst_i,          // synchronous reset, high
  input wire logic wb_cyc_i,       // Wishbone cycle
  input wire logic wb_stb_i,       // Wishbone strobe
  input wire logic wb_we_i,        // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i,// Wishbone write data
  output logic [31:0] wb_dat_o,    // Wishbone read data
  output logic wb_ack_o,           // Wishbone acknowledge
  output logic irq_o,              // level interrupt
  input wire logic uart_txd_i,     // transmit data from UART
  output logic uart_rxd_o,         // receive data to UART
  output logic xcvr_txd_o,         // transceiver transmit input
  input wire logic xcvr_rxd_i,     // transceiver receive output
  input wire logic test_txd_i,     // test pin driving transceiver
  output logic test_rxd_o          // test pin carrying receive
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] ctrl_ff;
  logic [15:0] config_ff;
  logic [3:0] status_ff;
  logic [3:0] mask_ff;
  logic [TIMER_WIDTH-1:0] compare_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic uart_rxd_ff;
  logic xcvr_txd_ff;
  logic test_rxd_ff;
  sync_link_pkg::hunt_state_type state_ff;
  sync_link_pkg::hunt_state_type nxt_state;
  logic [2:0] rise_cnt_ff;

  // ****************************************************************
  // decoded control
  // ****************************************************************
  logic gate_bit;
  logic test_mode;
  logic err_mask;
  logic bsd_mode;
  logic drive_low;

  assign gate_bit = ctrl_ff[sync_link_pkg::CTRL_GATE_BIT];
  assign test_mode = ctrl_ff[sync_link_pkg::CTRL_TEST_BIT];
  assign err_mask = ctrl_ff[sync_link_pkg::CTRL_ERRMASK_BIT];
  assign bsd_mode = config_ff[sync_link_pkg::CFG_BSD_BIT];
  assign drive_low = config_ff[sync_link_pkg::CFG_DRIVE_BIT];

  // ****************************************************************
  // bus access decode
  // ****************************************************************
  logic access;
  logic wr_en;
  logic rd_en;
  logic hit_ctrl;
  logic hit_config;
  logic hit_status;
  logic hit_mask;
  logic hit_timer;

  assign access = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_en = access & wb_we_i;
  assign rd_en = access & ~wb_we_i;
  assign hit_ctrl = wb_adr_i[7:2] == sync_link_pkg::CTRL_OFFSET[7:2];
  assign hit_config = wb_adr_i[7:2] == sync_link_pkg::CONFIG_OFFSET[7:2];
  assign hit_status = wb_adr_i[7:2] == sync_link_pkg::STATUS_OFFSET[7:2];
  assign hit_mask = wb_adr_i[7:2] == sync_link_pkg::MASK_OFFSET[7:2];
  assign hit_timer = wb_adr_i[7:2] == sync_link_pkg::TIMER_OFFSET[7:2];

  // byte-lane merge for 16-bit registers in the low half
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
      res[7:0] = dat[7:0];
    if (sel[1])
      res[15:8] = dat[15:8];
    return res;
  endfunction

  // ****************************************************************
  // bus edges and break pulse timer
  // ****************************************************************
  logic bus_rise;
  logic bus_fall;
  logic [TIMER_WIDTH-1:0] timer_count;
  logic timer_run;
  logic timer_match;
  logic timer_ovf;

  bus_edge_detect u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(xcvr_rxd_i),
    .rise_o(bus_rise),
    .fall_o(bus_fall)
  );

  // counts low time of every pulse in all modes
  pulse_timer #(
    .WIDTH(TIMER_WIDTH)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(bus_fall),
    .stop_i(bus_rise),
    .cmp_i(compare_ff),
    .count_o(timer_count),
    .run_o(timer_run),
    .match_o(timer_match),
    .ovf_o(timer_ovf)
  );

  // ****************************************************************
  // break and sync hunter, UART mode
  // ****************************************************************
  logic break_hit;

  assign break_hit = ~bsd_mode & timer_run & ~xcvr_rxd_i &
                     (timer_count == BREAK_CYCLES[TIMER_WIDTH-1:0]);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      sync_link_pkg::HUNT_ST:
      begin
        if (break_hit)
          nxt_state = sync_link_pkg::BREAK_ST;
      end
      sync_link_pkg::BREAK_ST:
      begin
        if (bus_rise)
          nxt_state = sync_link_pkg::SYNC_ST;
      end
      sync_link_pkg::SYNC_ST:
      begin
        if (break_hit)
          nxt_state = sync_link_pkg::BREAK_ST;
        else if (bus_rise && rise_cnt_ff == sync_link_pkg::SYNC_RISE_LAST)
          nxt_state = sync_link_pkg::DONE_ST;
      end
      sync_link_pkg::DONE_ST:
      begin
        if (break_hit)
          nxt_state = sync_link_pkg::BREAK_ST;
      end
      default:
        nxt_state = sync_link_pkg::HUNT_ST;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || bsd_mode)
      state_ff <= sync_link_pkg::HUNT_ST;
    else
      state_ff <= nxt_state;
  end

  // rising edges of the sync byte after the break
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_ff != sync_link_pkg::SYNC_ST)
      rise_cnt_ff <= 3'h0;
    else if (bus_rise)
      rise_cnt_ff <= rise_cnt_ff + 3'h1;
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_ff <= sync_link_pkg::CTRL_RESET;
    else if (wr_en && hit_ctrl)
      ctrl_ff <= merge16(ctrl_ff, wb_dat_i, wb_sel_i) & sync_link_pkg::CTRL_WMASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      config_ff <= sync_link_pkg::CONFIG_RESET;
    else if (wr_en && hit_config)
      config_ff <= merge16(config_ff, wb_dat_i, wb_sel_i) & sync_link_pkg::CONFIG_WMASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask_ff <= sync_link_pkg::MASK_RESET;
    else if (wr_en && hit_mask && wb_sel_i[0])
      mask_ff <= wb_dat_i[3:0];
  end

  // compare value shares the timer address; reads return the count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      compare_ff <= sync_link_pkg::COMPARE_RESET[TIMER_WIDTH-1:0];
    else if (wr_en && hit_timer)
      compare_ff <= merge16(compare_ff, wb_dat_i, wb_sel_i);
  end

  // ****************************************************************
  // sticky status, cleared by read, set wins
  // ****************************************************************
  logic [3:0] status_set;

  always_comb
  begin
    status_set = 4'h0;
    status_set[sync_link_pkg::STAT_BREAK_BIT] = bsd_mode & gate_bit & bus_rise;
    status_set[sync_link_pkg::STAT_OVF_BIT] = timer_ovf;
    status_set[sync_link_pkg::STAT_SYNC_BIT] = (state_ff == sync_link_pkg::SYNC_ST) &&
                                               (nxt_state == sync_link_pkg::DONE_ST);
    status_set[sync_link_pkg::STAT_CMP_BIT] = timer_match;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_ff <= sync_link_pkg::STATUS_RESET;
    else if (rd_en && hit_status)
      status_ff <= status_set;
    else
      status_ff <= status_ff | status_set;
  end

  // ****************************************************************
  // interrupt output
  // ****************************************************************
  logic [3:0] irq_allow;

  always_comb
  begin
    irq_allow = 4'hF;
    irq_allow[sync_link_pkg::STAT_OVF_BIT] = ~err_mask;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(status_ff & mask_ff & irq_allow);
  end

  // ****************************************************************
  // Wishbone answer: one wait state, unmapped reads zero
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= access;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_ff <= 32'h0000_0000;
    else if (rd_en)
    begin
      rdata_ff <= 32'h0000_0000;
      if (hit_ctrl)
        rdata_ff[15:0] <= ctrl_ff;
      else if (hit_config)
        rdata_ff[15:0] <= config_ff;
      else if (hit_status)
        rdata_ff[3:0] <= status_ff;
      else if (hit_mask)
        rdata_ff[3:0] <= mask_ff;
      else if (hit_timer)
        rdata_ff[TIMER_WIDTH-1:0] <= timer_count;
    end
  end

  // ****************************************************************
  // transceiver and UART routing
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      xcvr_txd_ff <= 1'b1;
    else if (test_mode)
      xcvr_txd_ff <= test_txd_i;
    else if (bsd_mode)
      xcvr_txd_ff <= ~drive_low;
    else
      xcvr_txd_ff <= uart_txd_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      test_rxd_ff <= 1'b1;
    else
      test_rxd_ff <= test_mode ? xcvr_rxd_i : 1'b1;
  end

  // UART sees idle high in test mode and while gated
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      uart_rxd_ff <= 1'b1;
    else if (test_mode)
      uart_rxd_ff <= 1'b1;
    else if (!bsd_mode && gate_bit && state_ff != sync_link_pkg::DONE_ST)
      uart_rxd_ff <= 1'b1;
    else
      uart_rxd_ff <= xcvr_rxd_i;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign irq_o = irq_ff;
  assign uart_rxd_o = uart_rxd_ff;
  assign xcvr_txd_o = xcvr_txd_ff;
  assign test_rxd_o = test_rxd_ff;

endmodule

// >>> include/sync_link_pkg.sv
// package for the break and sync gating block: register map, field positions,
// reset values, timing constants and the sync hunter state type.
// assumes a 100 MHz system clock and a classic Wishbone slave port.
package sync_link_pkg;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] MASK_OFFSET = 8'h0C;
  localparam logic [7:0] TIMER_OFFSET = 8'h10;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CTRL_GATE_BIT = 8;
  localparam int unsigned CTRL_TEST_BIT = 9;
  localparam int unsigned CTRL_ERRMASK_BIT = 10;
  localparam int unsigned CFG_BSD_BIT = 0;
  localparam int unsigned CFG_DRIVE_BIT = 1;
  localparam int unsigned STAT_BREAK_BIT = 0;
  localparam int unsigned STAT_OVF_BIT = 1;
  localparam int unsigned STAT_SYNC_BIT = 2;
  localparam int unsigned STAT_CMP_BIT = 3;
  localparam int unsigned STAT_WIDTH = 4;

  // ****************************************************************
  // reset values and writable masks
  // ****************************************************************
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h0700;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_WMASK = 16'h0003;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [15:0] COMPARE_RESET = 16'hFFFF;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BIT_TIME_NS = 52083;
  localparam int unsigned BREAK_BITS = 11;
  localparam int unsigned BREAK_MIN_NS = BIT_TIME_NS * BREAK_BITS;
  localparam int unsigned BREAK_CYCLES = (BREAK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SYNC_RISE_LAST = 3'h4;

  // ****************************************************************
  // sync hunter states
  // ****************************************************************
  typedef enum logic [3:0] {
    HUNT_ST = 4'h1,
    BREAK_ST = 4'h2,
    SYNC_ST = 4'h4,
    DONE_ST = 4'h8
  } hunt_state_type;

endpackage

// >>> test/bus_node.sv
// model of a node on the single-wire bus: open drain, pull-up.
// assumes its tasks are called from the clk_i domain.
`timescale 1ns/1ps
module bus_node (
  input wire logic clk_i, // system clock
  input wire logic txd_i, // drive from the transceiver
  output logic rxd_o      // resolved bus level
);
  logic pull_ff = 1'b1;

  // wired-and: either party pulls low
  assign rxd_o = txd_i & pull_ff;

  task drive(input logic v);
    @(posedge clk_i);
    pull_ff <= v;
  endtask

  task send_byte(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      drive(f[i]);
      repeat (bt - 1) @(posedge clk_i);
    end
  endtask
endmodule

// >>> test/sync_link_ctrl_properties.sv
// checker for the sync link control block, watching its ports only.
// assumes a classic Wishbone master that holds each request until ack.
`timescale 1ns/1ps
module sync_link_ctrl_properties (
  input wire logic clk_i,           // clock
  input wire logic rst_i,           // reset
  input wire logic wb_cyc_i,        // cycle
  input wire logic wb_stb_i,        // strobe
  input wire logic wb_we_i,         // write
  input wire logic [7:0] wb_adr_i,  // address
  input wire logic [3:0] wb_sel_i,  // selects
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o,        // ack
  input wire logic irq_o,           // interrupt
  input wire logic uart_txd_i,      // uart tx
  input wire logic uart_rxd_o,      // uart rx
  input wire logic xcvr_txd_o,      // xcvr tx
  input wire logic xcvr_rxd_i,      // xcvr rx
  input wire logic test_txd_i,      // test pin in
  input wire logic test_rxd_o       // test pin out
);
  logic test_ff;
  logic bsd_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************************************
  // mirror of mode bits, taken when the write is acknowledged
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      test_ff <= 1'b0;
      bsd_ff <= 1'b0;
    end
    else if (wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[1])
      test_ff <= wb_dat_i[9];
    else if (wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h01 && wb_sel_i[0])
      bsd_ff <= wb_dat_i[0];
  end

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  ctrl_bits_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h00
    |-> (wb_dat_o[15:0] & 16'hF8FF) == 16'h0000)
    else $error("control read shows unwritable bits");
  reset_out_a: assert property (disable iff (1'b0) rst_i
    |=> !wb_ack_o && !irq_o && uart_rxd_o && xcvr_txd_o && test_rxd_o)
    else $error("outputs not at reset values");
  test_tx_a: assert property (test_ff && $past(test_ff)
    |-> xcvr_txd_o == $past(test_txd_i))
    else $error("test pin not driving transceiver");
  test_rx_a: assert property (test_ff && $past(test_ff)
    |-> test_rxd_o == $past(xcvr_rxd_i))
    else $error("test pin not carrying receive");
  norm_tx_a: assert property (!test_ff && !$past(test_ff) && !bsd_ff && !$past(bsd_ff)
    && !$past(rst_i) |-> xcvr_txd_o == $past(uart_txd_i))
    else $error("uart not driving transceiver");
  norm_rx_a: assert property (!test_ff && !$past(test_ff) && !$past(rst_i)
    |-> test_rxd_o)
    else $error("test pin active outside test mode");

  cover property (test_ff ##1 test_ff);
  cover property (wb_ack_o && !wb_we_i);
  cover property ($rose(irq_o));
endmodule

bind sync_link_ctrl sync_link_ctrl_properties i_sync_link_ctrl_properties (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .uart_txd_i(uart_txd_i),
  .uart_rxd_o(uart_rxd_o), .xcvr_txd_o(xcvr_txd_o), .xcvr_rxd_i(xcvr_rxd_i),
  .test_txd_i(test_txd_i), .test_rxd_o(test_rxd_o)
);

// >>> test/sync_link_ctrl_tb.sv
// testbench for the sync link control block.
// assumes the bus node model and the bound checker are compiled too.
`timescale 1ns/1ps
module sync_link_ctrl_tb;
  localparam int unsigned BRK = 40;
  localparam logic [7:0] CTL = sync_link_pkg::CTRL_OFFSET;
  localparam logic [7:0] CFG = sync_link_pkg::CONFIG_OFFSET;
  localparam logic [7:0] STA = sync_link_pkg::STATUS_OFFSET;
  localparam logic [7:0] MSK = sync_link_pkg::MASK_OFFSET;
  localparam logic [7:0] TMR = sync_link_pkg::TIMER_OFFSET;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat;
  logic uart_txd;
  logic test_txd;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic irq;
  logic uart_rxd;
  logic xcvr_txd;
  logic xcvr_rxd;
  logic test_rxd;
  logic watch_hi = 1'b0;
  logic hi_bad = 1'b0;
  logic [31:0] q;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;

  sync_link_ctrl #(.BREAK_CYCLES(BRK)) i_sync_link_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq), .uart_txd_i(uart_txd),
    .uart_rxd_o(uart_rxd), .xcvr_txd_o(xcvr_txd), .xcvr_rxd_i(xcvr_rxd),
    .test_txd_i(test_txd), .test_rxd_o(test_rxd));
  bus_node i_bus_node (.clk_i(clk_i), .txd_i(xcvr_txd), .rxd_o(xcvr_rxd));

  initial forever #5 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    cycles++;
    if (watch_hi && uart_rxd !== 1'b1)
      hi_bad <= 1'b1;
    if (cycles == 80000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task print_verdict();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat <= d;
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 4'hF);
  endtask

  task rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0, 4'hF);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_regs();
    logic [7:0] ra [6];
    ra = '{CTL, CFG, STA, MSK, TMR, 8'h1C};
    foreach (ra[i])
    begin
      rd(ra[i]);
      check(q, 32'h0);
    end
    wr(8'h1C, 32'hFFFF);
    // low lane only: control bits sit in the high lane
    xfer(CTL, 1'b1, 32'hFFFF, 4'h1);
    rd(CTL);
    check(q, 32'h0);
    xfer(CTL, 1'b1, 32'hFFFF, 4'h2);
    rd(CTL);
    check(q, 32'h0700);
    wr(CTL, 32'h0);
    rd(CTL);
    check(q, 32'h0);
    $display("t_regs done");
  endtask

  task t_test();
    wr(CTL, 32'h0200);
    test_txd <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(xcvr_txd, 32'h0);
    check(test_rxd, 32'h0);
    test_txd <= 1'b1;
    wr(CTL, 32'h0);
    uart_txd <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(xcvr_txd, 32'h0);
    check(test_rxd, 32'h1);
    uart_txd <= 1'b1;
    $display("t_test done");
  endtask

  task t_gate();
    wr(CTL, 32'h0100);
    watch_hi <= 1'b1;
    i_bus_node.drive(1'b0);
    repeat (BRK + 5) @(posedge clk_i);
    i_bus_node.drive(1'b1);
    repeat (8) @(posedge clk_i);
    i_bus_node.send_byte(8'h55, 8);
    watch_hi <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(hi_bad, 32'h0);
    rd(STA);
    check(q & 32'h4, 32'h4);
    i_bus_node.drive(1'b0);
    repeat (3) @(posedge clk_i);
    check(uart_rxd, 32'h0);
    wr(CTL, 32'h0);
    repeat (BRK + 5) @(posedge clk_i);
    check(uart_rxd, 32'h0);
    i_bus_node.drive(1'b1);
    $display("t_gate done");
  endtask

  task t_bsd_read();
    logic [31:0] t1;
    wr(CFG, 32'h1);
    wr(CTL, 32'h0100);
    wr(MSK, 32'h1);
    rd(STA);
    i_bus_node.drive(1'b0);
    repeat (20) @(posedge clk_i);
    i_bus_node.drive(1'b1);
    repeat (4) @(posedge clk_i);
    check(irq, 32'h1);
    rd(STA);
    check(q & 32'h1, 32'h1);
    rd(TMR);
    t1 = q;
    check(32'(t1 >= 32'h13 && t1 <= 32'h17), 32'h1);
    rd(TMR);
    check(q, t1);
    check(irq, 32'h0);
    $display("t_bsd_read done");
  endtask

  task t_bsd_write();
    int n;
    logic [31:0] t1;
    wr(CTL, 32'h0);
    wr(TMR, 32'h1E);
    wr(MSK, 32'h9);
    rd(STA);
    wr(CFG, 32'h3);
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      n++;
    end
    check(irq, 32'h1);
    wr(CFG, 32'h1);
    repeat (4) @(posedge clk_i);
    rd(STA);
    check(q & 32'h9, 32'h8);
    rd(TMR);
    t1 = q;
    check(32'(t1 >= 32'h1E), 32'h1);
    repeat (5) @(posedge clk_i);
    rd(TMR);
    check(q, t1);
    $display("t_bsd_write done");
  endtask

  task t_ovf();
    wr(CTL, 32'h0400);
    wr(MSK, 32'h2);
    rd(STA);
    i_bus_node.drive(1'b0);
    repeat (65600) @(posedge clk_i);
    i_bus_node.drive(1'b1);
    repeat (4) @(posedge clk_i);
    check(irq, 32'h0);
    wr(CTL, 32'h0);
    repeat (3) @(posedge clk_i);
    check(irq, 32'h1);
    rd(STA);
    check(q & 32'h2, 32'h2);
    $display("t_ovf done");
  endtask

  initial
  begin
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_adr <= 8'h00;
    wb_sel <= 4'h0;
    wb_dat <= 32'h0;
    uart_txd <= 1'b1;
    test_txd <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_test();
    t_gate();
    t_bsd_read();
    t_bsd_write();
    t_ovf();
    print_verdict();
  end
endmodule
